// ### logic/uart_tx_pkg.sv
// constants, bus carrier and state types of the asynchronous transmitter
package uart_tx_pkg;
    // register bus shape
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [2:0] OFF_CTRL     = 3'h0;
    localparam logic [2:0] OFF_TXBUF    = 3'h1;
    localparam logic [2:0] OFF_BAUD     = 3'h2;
    localparam logic [2:0] OFF_PORT     = 3'h3;
    localparam logic [2:0] OFF_IRQ_EN   = 3'h4;
    localparam logic [2:0] OFF_IRQ_STAT = 3'h5;
    localparam logic [2:0] OFF_IRQ_MASK = 3'h6;
    // transmit_control_status fields
    localparam int CTRL_NINE_SEL    = 6;
    localparam int CTRL_TX_EN       = 5;
    localparam int CTRL_SYNC        = 4;
    localparam int CTRL_HIGH_BAUD   = 2;
    localparam int CTRL_SHIFT_EMPTY = 1;
    localparam int CTRL_NINTH       = 0;
    // port control and interrupt enable fields
    localparam int PORT_SERIAL_PORT_ENABLE  = 7;
    localparam int IEN_GLOBAL = 7;
    localparam int IEN_PERIPH = 6;
    localparam int IEN_TX     = 4;
    // interrupt status fields, low bits are sticky events
    localparam int STAT_TXBF     = 4;
    localparam int EV_FRAME_DONE = 0;
    localparam int EV_LOADED     = 1;
    localparam int NUM_EV        = 2;
    // reset values
    localparam logic [7:0] RST_BAUD = 8'h00;
    localparam logic [1:0] RST_MASK = 2'h0;
    // baud timing: samples per bit for fast and slow rate
    localparam logic [6:0] PRESCALE_HIGH = 7'h10;
    localparam logic [6:0] PRESCALE_LOW  = 7'h40;
    // index of the last data bit for 8- and 9-bit characters
    localparam logic [3:0] BIT_LAST_8 = 4'h7;
    localparam logic [3:0] BIT_LAST_9 = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } tx_state_t;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        tx_state_t   st;
        logic [8:0]  shreg;
        logic [3:0]  bitcnt;
        logic        frame_nine;
        logic        frame_ninth;
        logic [8:0]  buf_data;
        logic        buf_full;
        logic        nine;
        logic        transmit_enable;
        logic        sync;
        logic        high_baud_select;
        logic        ninth_data_bit;
        logic        serial_port_enable;
        logic [7:0]  baud;
        logic        transmit_irq_enable;
        logic        global_irq_enable;
        logic        peripheral_irq_enable;
        logic [1:0]  ev;
        logic [1:0]  mask;
        logic [7:0]  rdata;
        logic        line;
    } tx_regs_t;

    typedef struct packed {
        logic [7:0] div_cnt;
        logic [6:0] pre_cnt;
    } baud_regs_t;
endpackage : uart_tx_pkg

// ### logic/baud_tick_gen.sv
// bit-period tick generator from divisor and rate select
module baud_tick_gen
    import uart_tx_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic [7:0] i_divisor,
    input  wire logic       i_high_baud,
    input  wire logic       i_restart,
    output logic            o_tick
);
    baud_regs_t r_reg;
    baud_regs_t r_next;
    logic [6:0] last_pre;
    logic       div_wrap;

    // one sample lasts divisor+1 clocks, one bit a prescale of samples
    assign last_pre = 7'((i_high_baud ? PRESCALE_HIGH : PRESCALE_LOW) - 7'h01);
    assign div_wrap = (r_reg.div_cnt == i_divisor);
    assign o_tick   = div_wrap && (r_reg.pre_cnt == last_pre);

    // restart aligns the bit period to the first bit of a frame
    always_comb begin
        r_next = r_reg;
        if (i_restart) begin
            r_next.div_cnt = 8'h00;
            r_next.pre_cnt = 7'h00;
        end else if (div_wrap) begin
            r_next.div_cnt = 8'h00;
            r_next.pre_cnt = (r_reg.pre_cnt == last_pre) ? 7'h00 : 7'(r_reg.pre_cnt + 7'h01);
        end else begin
            r_next.div_cnt = 8'(r_reg.div_cnt + 8'h01);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // a restart always leaves counters at zero
    a_restart_clears: assert property (i_restart |=> (r_reg.div_cnt == 8'h00) && (r_reg.pre_cnt == 7'h00))
        else $error("baud counters not cleared by restart");

    // no two ticks back to back, a bit is at least sixteen clocks
    a_tick_spacing: assert property (o_tick |=> !o_tick)
        else $error("baud ticks back to back");
endmodule : baud_tick_gen

// ### logic/async_uart_transmitter.sv
// asynchronous serial transmitter with buffer, shift register and registers
//
// The strobed register port and the placing of the registers were left to the implementer.
module async_uart_transmitter
    import uart_tx_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_tx_line,
    output logic                   o_tx_oe,
    output logic                   o_shift_empty,
    output logic                   o_tx_buffer_flag,
    output logic                   o_irq
);
    tx_regs_t   r_reg;
    tx_regs_t   r_next;
    bus_req_t   req;
    logic       tick;
    logic       restart;
    logic       active;
    logic       load;
    logic       txbf;
    logic       tx_irq;
    logic [3:0] last_bit;

    assign req = '{rd: i_rd, wr: i_wr, addr: i_addr, wdata: i_wdata};

    baud_tick_gen u_baud (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_divisor   (r_reg.baud),
        .i_high_baud (r_reg.high_baud_select),
        .i_restart   (restart),
        .o_tick      (tick)
    );

    // asynchronous transmit configuration
    assign active = r_reg.serial_port_enable && r_reg.transmit_enable && !r_reg.sync;

    // buffer empties into the shift register when idle or at a stop bit's end
    assign load = active && r_reg.buf_full &&
                  ((r_reg.st == ST_IDLE) || ((r_reg.st == ST_STOP) && tick));

    assign last_bit = r_reg.frame_nine ? BIT_LAST_9 : BIT_LAST_8;

    // buffer flag: enabled and nothing waiting in the buffer
    assign txbf = r_reg.transmit_enable && !r_reg.buf_full;

    // buffer interrupt path needs all three enables; shift_empty stays out of it
    assign tx_irq = txbf && r_reg.transmit_irq_enable && r_reg.global_irq_enable && r_reg.peripheral_irq_enable;

    // outputs
    assign o_rdata          = r_reg.rdata;
    assign o_tx_line        = r_reg.line;
    assign o_tx_oe          = r_reg.serial_port_enable;
    assign o_shift_empty    = (r_reg.st == ST_IDLE);
    assign o_tx_buffer_flag = txbf;
    assign o_irq            = tx_irq || (|(r_reg.ev & r_reg.mask));

    // next state: events, shifter, bus writes, read data
    always_comb begin
        logic [7:0] rd_word;
        rd_word = 8'h00;
        r_next  = r_reg;
        restart = 1'b0;

        // clear sticky bits first so a same-cycle event still sets them
        if (req.wr && (req.addr == OFF_IRQ_STAT)) begin
            r_next.ev = r_reg.ev & ~req.wdata[NUM_EV-1:0];
        end

        // shifter sequence
        case (r_reg.st)
            ST_IDLE: begin
                r_next.line = 1'b1;
            end
            ST_START: begin
                if (tick) begin
                    r_next.st     = ST_DATA;
                    r_next.line   = r_reg.shreg[0];
                    r_next.bitcnt = 4'h0;
                end
            end
            ST_DATA: begin
                if (tick) begin
                    if (r_reg.bitcnt == last_bit) begin
                        r_next.st   = ST_STOP;
                        r_next.line = 1'b1;
                    end else begin
                        r_next.shreg  = r_reg.shreg >> 1;
                        r_next.line   = r_reg.shreg[1];
                        r_next.bitcnt = 4'(r_reg.bitcnt + 4'h1);
                    end
                end
            end
            ST_STOP: begin
                if (tick) begin
                    r_next.st                = ST_IDLE;
                    r_next.ev[EV_FRAME_DONE] = 1'b1;
                end
            end
            default: begin
                r_next.st   = ST_IDLE;
                r_next.line = 1'b1;
            end
        endcase

        // transfer: all nine bits at once, start bit follows at once
        if (load) begin
            r_next.st             = ST_START;
            r_next.line           = 1'b0;
            r_next.shreg          = r_reg.buf_data;
            r_next.frame_nine     = r_reg.nine;
            r_next.frame_ninth    = r_reg.buf_data[8];
            r_next.buf_full       = 1'b0;
            r_next.ev[EV_LOADED]  = 1'b1;
            restart               = 1'b1;
        end

        // leaving asynchronous transmit drops the frame; disabling flushes
        if (!active && (r_reg.st != ST_IDLE)) begin
            r_next.st   = ST_IDLE;
            r_next.line = 1'b1;
        end
        if (!r_reg.transmit_enable || !r_reg.serial_port_enable) begin
            r_next.buf_full = 1'b0;
        end

        // register writes; the shift-empty bit has no write path
        if (req.wr) begin
            case (req.addr)
                OFF_CTRL: begin
                    r_next.nine = req.wdata[CTRL_NINE_SEL];
                    r_next.transmit_enable = req.wdata[CTRL_TX_EN];
                    r_next.sync = req.wdata[CTRL_SYNC];
                    r_next.high_baud_select = req.wdata[CTRL_HIGH_BAUD];
                    r_next.ninth_data_bit = req.wdata[CTRL_NINTH];
                end
                OFF_TXBUF: begin
                    // ninth bit taken as it stands now, so it must be set first
                    r_next.buf_data = {r_reg.ninth_data_bit, req.wdata};
                    r_next.buf_full = 1'b1;
                end
                OFF_BAUD: begin
                    r_next.baud = req.wdata;
                end
                OFF_PORT: begin
                    r_next.serial_port_enable = req.wdata[PORT_SERIAL_PORT_ENABLE];
                end
                OFF_IRQ_EN: begin
                    r_next.global_irq_enable  = req.wdata[IEN_GLOBAL];
                    r_next.peripheral_irq_enable = req.wdata[IEN_PERIPH];
                    r_next.transmit_irq_enable = req.wdata[IEN_TX];
                end
                OFF_IRQ_MASK: begin
                    r_next.mask = req.wdata[NUM_EV-1:0];
                end
                default: begin
                    r_next.mask = r_reg.mask;
                end
            endcase
        end

        // read data stand in the cycle after the strobe only
        if (req.rd) begin
            case (req.addr)
                OFF_CTRL: begin
                    rd_word[CTRL_NINE_SEL]    = r_reg.nine;
                    rd_word[CTRL_TX_EN]       = r_reg.transmit_enable;
                    rd_word[CTRL_SYNC]        = r_reg.sync;
                    rd_word[CTRL_HIGH_BAUD]   = r_reg.high_baud_select;
                    rd_word[CTRL_SHIFT_EMPTY] = (r_reg.st == ST_IDLE);
                    rd_word[CTRL_NINTH]       = r_reg.ninth_data_bit;
                end
                OFF_TXBUF: begin
                    rd_word = r_reg.buf_data[7:0];
                end
                OFF_BAUD: begin
                    rd_word = r_reg.baud;
                end
                OFF_PORT: begin
                    rd_word[PORT_SERIAL_PORT_ENABLE] = r_reg.serial_port_enable;
                end
                OFF_IRQ_EN: begin
                    rd_word[IEN_GLOBAL] = r_reg.global_irq_enable;
                    rd_word[IEN_PERIPH] = r_reg.peripheral_irq_enable;
                    rd_word[IEN_TX]     = r_reg.transmit_irq_enable;
                end
                OFF_IRQ_STAT: begin
                    rd_word[STAT_TXBF]    = txbf;
                    rd_word[NUM_EV-1:0]   = r_reg.ev;
                end
                OFF_IRQ_MASK: begin
                    rd_word[NUM_EV-1:0] = r_reg.mask;
                end
                default: begin
                    rd_word = 8'h00;
                end
            endcase
        end
        r_next.rdata = rd_word;
    end

    // single state register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_reg          <= '0;
            r_reg.st       <= ST_IDLE;
            r_reg.line     <= 1'b1;
            r_reg.baud     <= RST_BAUD;
            r_reg.mask     <= RST_MASK;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // a transfer drops the empty flag on the next edge
    a_empty_drops: assert property (load |=> !o_shift_empty)
        else $error("shift empty flag still set after transfer");

    // the flag only comes back at the end of a stop bit or when leaving asynchronous transmit drops the frame
    a_empty_after_stop: assert property (
        $rose(o_shift_empty) |-> ($past(r_reg.st) == ST_STOP) || !$past(active))
        else $error("shift empty flag rose before the stop bit ended");

    // a control write that keeps asynchronous transmit on cannot set the empty flag while shifting
    a_empty_read_only: assert property (
        (req.wr && (req.addr == OFF_CTRL) && active && req.wdata[CTRL_TX_EN] &&
         !req.wdata[CTRL_SYNC] && (r_reg.st == ST_DATA) && !tick) |=> !o_shift_empty)
        else $error("shift empty flag changed by a register write");

    // the data phase runs for exactly eight or nine bits
    a_data_bit_count: assert property (
        $rose(r_reg.st == ST_STOP) |-> $past(r_reg.bitcnt) == (r_reg.frame_nine ? BIT_LAST_9 : BIT_LAST_8))
        else $error("wrong number of data bits in frame");

    // the ninth bit on the line is the buffered ninth bit
    a_ninth_on_line: assert property (
        (r_reg.st == ST_DATA) && (r_reg.bitcnt == BIT_LAST_9) |-> o_tx_line == r_reg.frame_ninth)
        else $error("ninth data bit not sent last");

    // a character written while busy waits for the stop bit
    a_buffer_holds: assert property (
        r_reg.buf_full && active && (r_reg.st == ST_DATA) |=> r_reg.buf_full)
        else $error("buffer released while shift register busy");

    // back to back: next start bit right after a stop bit
    a_no_idle_gap: assert property (
        (r_reg.st == ST_STOP) && tick && load |=> (r_reg.st == ST_START) && !o_tx_line)
        else $error("idle gap inserted between characters");

    // start bit low and stop bit high for their whole period
    a_frame_levels: assert property (
        ((r_reg.st == ST_START) |-> !o_tx_line) and ((r_reg.st == ST_STOP) |-> o_tx_line))
        else $error("start or stop bit at wrong level");

    // a buffer write while idle starts the start bit within two cycles
    a_write_starts: assert property (
        req.wr && (req.addr == OFF_TXBUF) && active && (r_reg.st == ST_IDLE) && !r_reg.buf_full
        ##1 active |-> ##1 (r_reg.st == ST_START) && !o_tx_line)
        else $error("buffer write did not start a frame");

    // buffer write clears the flag on the next edge
    a_flag_on_write: assert property (
        req.wr && (req.addr == OFF_TXBUF) |=> !o_tx_buffer_flag)
        else $error("buffer flag still set after buffer write");

    // a transfer with no bus write beside it sets the flag again
    a_flag_on_load: assert property (
        load && !req.wr |=> o_tx_buffer_flag)
        else $error("buffer flag not set again after transfer");

    // enabling with an empty buffer sets the flag on the next edge
    a_flag_on_enable: assert property (
        req.wr && (req.addr == OFF_CTRL) && req.wdata[CTRL_TX_EN] && !r_reg.buf_full |=> o_tx_buffer_flag)
        else $error("buffer flag not set by transmit enable");

    // all enables with flag set raise the interrupt at once
    a_irq_raised: assert property (
        o_tx_buffer_flag && r_reg.transmit_irq_enable && r_reg.global_irq_enable && r_reg.peripheral_irq_enable |-> o_irq)
        else $error("interrupt missing with all enables set");
endmodule : async_uart_transmitter

// ### test/serial_receiver_model.sv
// behavioural remote receiver that decodes frames seen on the transmit line
module serial_receiver_model (
    input  wire logic        i_clk,
    input  wire logic        i_line,
    input  wire logic        i_nine,
    input  wire logic [15:0] i_bit_len,
    output logic      [8:0]  o_data,
    output logic      [31:0] o_frames,
    output logic      [31:0] o_start_cyc,
    output logic             o_frame_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cyc;
    logic [31:0] stamp;
    int          nbits;

    // free-running cycle count, only used to time-stamp start bits
    initial cyc = 32'h0;
    always @(posedge i_clk) cyc <= cyc + 32'h1;

    // a start edge is confirmed at mid-bit so a short glitch is not taken for a frame
    initial begin
        o_data = 9'h000;
        o_frames = 32'h0;
        o_start_cyc = 32'h0;
        o_frame_err = 1'b0;
        forever begin
            @(negedge i_line);
            stamp = cyc;
            repeat (i_bit_len / 2) @(posedge i_clk);
            if (i_line === 1'b0) begin
                nbits = i_nine ? 9 : 8;
                o_data = 9'h000;
                // data bits arrive lsb first, a ninth bit marks an address byte
                for (int i = 0; i < nbits; i++) begin
                    repeat (i_bit_len) @(posedge i_clk);
                    o_data[i] = i_line;
                end
                repeat (i_bit_len) @(posedge i_clk);
                if (i_line !== 1'b1) o_frame_err = 1'b1;
                o_start_cyc = stamp;
                o_frames = o_frames + 32'h1;
            end
        end
    end
endmodule : serial_receiver_model

// ### test/async_uart_transmitter_test.sv
// self-checking bench for the asynchronous transmitter against a remote receiver
module async_uart_transmitter_test import uart_tx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] BIT_LEN = 16'h0010; // divisor 0 with the fast rate
    logic              clk, resetn, wr, rd, nine, tx_line, tx_oe, shift_empty, tx_bf, irq, rx_err;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rd_val;
    logic [8:0]        rx_data;
    logic [31:0]       rx_frames, rx_start, nf, prev_start, cur_start;
    int                err_total, comparisons;

    async_uart_transmitter i_async_uart_transmitter (.i_clk(clk), .i_resetn(resetn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_tx_line(tx_line), .o_tx_oe(tx_oe),
        .o_shift_empty(shift_empty), .o_tx_buffer_flag(tx_bf), .o_irq(irq));
    serial_receiver_model i_serial_receiver_model (.i_clk(clk), .i_line(tx_line), .i_nine(nine),
        .i_bit_len(BIT_LEN), .o_data(rx_data), .o_frames(rx_frames), .o_start_cyc(rx_start),
        .o_frame_err(rx_err));

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // one-cycle strobes launched just after an edge
    task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rd_val = rdata;
    endtask : bus_read

    task automatic settle();
        @(posedge clk);
        #1;
    endtask : settle

    // bounded wait for the next frame, then check it and the empty flag around its stop bit
    task automatic frame_expect(input logic [8:0] exp, input logic last);
        nf++;
        for (int k = 0; k < 400 && rx_frames != nf; k++) settle();
        check(rx_frames[15:0], nf[15:0]);
        prev_start = cur_start;
        cur_start = rx_start;
        check({7'h00, rx_data}, {7'h00, exp});
        check({15'h0, rx_err}, 16'h0);
        check({15'h0, shift_empty}, 16'h0);
        repeat (BIT_LEN) @(posedge clk);
        #1 check({15'h0, shift_empty}, {15'h0, last});
    endtask : frame_expect

    task automatic t_reset();
        check({11'h0, tx_line, tx_oe, shift_empty, tx_bf, irq}, 16'h0014);
        bus_read(OFF_CTRL);
        check({8'h0, rd_val}, 16'h0002);
        bus_write(OFF_CTRL, 8'h00);
        bus_read(OFF_CTRL);
        check({8'h0, rd_val}, 16'h0002);
        bus_read(3'h7);
        check({8'h0, rd_val}, 16'h0000);
    endtask : t_reset

    // the transmit enable alone and each pair of enables, then all three together
    task automatic t_enable_irq();
        logic [7:0] ens [5];
        logic [4:0] exps;
        ens = '{8'h10, 8'h90, 8'h50, 8'hC0, 8'hD0};
        exps = 5'b10000;
        bus_write(OFF_BAUD, RST_BAUD);
        bus_write(OFF_PORT, 8'h80);
        bus_write(OFF_CTRL, 8'h24);
        settle();
        check({14'h0, tx_oe, tx_bf}, 16'h0003);
        for (int i = 0; i < 5; i++) begin
            bus_write(OFF_IRQ_EN, ens[i]);
            settle();
            check({15'h0, irq}, {15'h0, exps[i]});
        end
        bus_write(OFF_IRQ_EN, 8'h00);
    endtask : t_enable_irq

    task automatic t_single();
        bus_write(OFF_TXBUF, 8'hA5);
        // buffer full before the transfer edge
        #1;
        check({14'h0, tx_bf, shift_empty}, 16'h0001);
        settle();
        check({13'h0, tx_bf, shift_empty, tx_line}, 16'h0004);
        frame_expect(9'h0A5, 1'b1);
    endtask : t_single

    // the second byte waits in the buffer and follows with no idle gap
    task automatic t_back2back();
        bus_write(OFF_TXBUF, 8'h5A);
        repeat (4) @(posedge clk);
        bus_write(OFF_TXBUF, 8'h0F);
        settle();
        check({14'h0, tx_bf, shift_empty}, 16'h0000);
        // rewriting control in the data phase leaves the empty flag low
        repeat (20) @(posedge clk);
        bus_write(OFF_CTRL, 8'h24);
        settle();
        check({15'h0, shift_empty}, 16'h0000);
        frame_expect(9'h05A, 1'b0);
        frame_expect(9'h00F, 1'b1);
        check(cur_start[15:0] - prev_start[15:0], BIT_LEN * 16'd10);
    endtask : t_back2back

    task automatic t_nine();
        nine = 1'b1;
        bus_write(OFF_CTRL, 8'h65);
        bus_write(OFF_TXBUF, 8'h3C);
        frame_expect(9'h13C, 1'b1);
        bus_write(OFF_CTRL, 8'h64);
        bus_write(OFF_TXBUF, 8'hC3);
        frame_expect(9'h0C3, 1'b1);
        bus_write(OFF_CTRL, 8'h24);
        nine = 1'b0;
    endtask : t_nine

    // sticky events raise the level output only when unmasked, write one clears
    task automatic t_events();
        bus_read(OFF_IRQ_STAT);
        check({8'h0, rd_val}, 16'h0013);
        check({15'h0, irq}, 16'h0000);
        bus_write(OFF_IRQ_MASK, 8'h01);
        settle();
        check({15'h0, irq}, 16'h0001);
        bus_write(OFF_IRQ_STAT, 8'h03);
        settle();
        check({15'h0, irq}, 16'h0000);
        bus_read(OFF_IRQ_STAT);
        check({8'h0, rd_val}, 16'h0010);
        bus_write(OFF_IRQ_MASK, 8'h00);
    endtask : t_events

    // leaving asynchronous mode mid-start bit must abandon the frame
    task automatic t_abort();
        bus_write(OFF_TXBUF, 8'h00);
        bus_write(OFF_CTRL, 8'h34);
        settle();
        settle();
        check({14'h0, tx_line, shift_empty}, 16'h0003);
        repeat (BIT_LEN * 12) @(posedge clk);
        check(rx_frames[15:0], nf[15:0]);
        bus_write(OFF_CTRL, 8'h24);
    endtask : t_abort

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        nine = 1'b0;
        nf = 32'h0;
        cur_start = 32'h0;
        prev_start = 32'h0;
        err_total = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        settle();
        t_reset();
        t_enable_irq();
        t_single();
        t_back2back();
        t_nine();
        t_events();
        t_abort();
        test_done();
    end

    // watchdog: the tests need about 1150 cycles, allow several times that
    initial begin
        #400000;
        err_total++;
        test_done();
    end
endmodule : async_uart_transmitter_test
